// File: common/sbc_regs.vh
// register offsets, field positions and timing counts of the serial bus control block
`ifndef SBC_REGS_VH
`define SBC_REGS_VH

// register addresses on the special-function register port
`define SBC_CTRL_STATUS_ADDR 8'hc0
`define SBC_CONFIG_ADDR      8'hc1

// configuration register fields
`define SBC_CF_ENABLE  7
`define SBC_CF_SUPP    6
`define SBC_CF_BUSY    5
`define SBC_CF_EXTENDED_SETUP_HOLD 4
`define SBC_CF_TOE     3
`define SBC_CF_FTE     2
`define SBC_CF_CS_HI   1
`define SBC_CF_CS_LO   0

// control and status register fields
`define SBC_CN_MASTER  7
`define SBC_CN_TRANSMITTER_INDICATOR  6
`define SBC_CN_BEGIN   5
`define SBC_CN_HALT    4
`define SBC_CN_ACK_NEEDED   3
`define SBC_CN_ARBL    2
`define SBC_CN_ACK     1
`define SBC_CN_EVENT   0

// reset values
`define SBC_CTRL_STATUS_RST 8'h00
`define SBC_CONFIG_RST      8'h00

// clock source codes
`define SBC_CS_T0  2'h0
`define SBC_CS_T1  2'h1
`define SBC_CS_T2H 2'h2
`define SBC_CS_T2L 2'h3

// sda timing in system clocks
`define SBC_HOLD_STD  5'h03
`define SBC_HOLD_EXT  5'h0c
`define SBC_SETUP_STD 5'h01
`define SBC_SETUP_EXT 5'h0b

// bus free after more than this many clock-source periods
`define SBC_FREE_PERIODS 4'ha
// clock-source periods of the master scl high phase
`define SBC_HIGH_TICKS   2'h2

`endif

// File: src/sbc_smbus_ctrl.v
// serial bus control, configuration and byte engine of a two-wire master/slave port
// Function
// (RQ1) enable set: watch SDA and SCL; clear: interface off.
// (RQ2) slave suppress blocks slave events and interrupts; master events continue.
// (RQ3) busy set during transfer, cleared by STOP or bus-free timeout.
// (RQ4) timeout enable: timer 3 reloads while SCL high, counts while low.
// (RQ5) timer 3 split mode: only the high byte is held in reload.
// (RQ6) free timeout: bus free after SCL and SDA high over 10 source periods.
// (RQ7) clock select picks timer 0, timer 1, timer 2 high or low overflow.
// (RQ8) begin flag: enter master, START when bus free; flag not cleared.
// (RQ9) begin flag as active master: repeated START after next acknowledge cycle.
// (RQ10) halt flag: STOP after next acknowledge cycle; cleared once STOP sent.
// (RQ11) both flags as master: STOP then START.
// (RQ12) ack needed set per received byte, cleared after acknowledge cycle.
// (RQ13) ack write drives SDA at once; SCL low until byte event cleared.
// (RQ14) as transmitter, ack bit records received acknowledge level.
// (RQ15) address answered with NACK: slave events ignored until next START.
// (RQ16) arbitration lost on SCL low at STOP/restart, SDA low, unwanted restart.
// (RQ17) arbitration lost cleared whenever byte event flag is cleared.
// (RQ18) byte event flag stalls bus with SCL low; only software clears it.
// (RQ19) byte event set on START, lost arbitration, byte, address, STOP.
// (RQ20) master indicator set on START, cleared on STOP or lost arbitration.
// (RQ21) transmitter set on START or early data write; cleared otherwise.
// (RQ22) halt reads one on slave STOP; begin reads one after START plus address.
// (RQ23) bus-free timeout acts like STOP: byte event and halt flag set.
// (RQ24) master SCL low and high last at least one source period.
// (RQ25) extended timing: setup 11, hold 12 clocks; else hold 3.
// (RQ26) disable releases lines and returns engine to idle.
`timescale 1ns/100ps
`include "sbc_regs.vh"

module sbc_smbus_ctrl (
  // clock and reset
  input  wire       ref_clk,
  input  wire       resetn,
  // special-function register port
  input  wire [7:0] sfr_addr,
  input  wire       sfr_wr,
  input  wire [7:0] sfr_wdata,
  output reg  [7:0] sfr_rdata,
  // transmit byte written by software
  input  wire       data_wr,
  input  wire [7:0] data_in,
  // received bytes
  output reg  [7:0] rx_data,
  output reg        rx_valid,
  input  wire       rx_ready,
  // timer overflows and timer 3 control
  input  wire       t0_ovf,
  input  wire       t1_ovf,
  input  wire       t2h_ovf,
  input  wire       t2l_ovf,
  input  wire       timer3_split,
  output reg        t3_reload_hi,
  output reg        t3_reload_lo,
  // bus pins
  input  wire       scl_in,
  output reg        scl_out,
  output reg        scl_oe_n,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe_n
);

  localparam ST_IDLE   = 4'h0;
  localparam ST_START  = 4'h1;
  localparam ST_WAIT   = 4'h2;
  localparam ST_LOW    = 4'h3;
  localparam ST_HIGH   = 4'h4;
  localparam ST_PUSH   = 4'h5;
  localparam ST_STOP1  = 4'h6;
  localparam ST_STOP2  = 4'h7;
  localparam ST_RST1   = 4'h8;
  localparam ST_RST2   = 4'h9;

  reg  [3:0] state_r;
  reg  [4:0] cnt_r;
  reg  [1:0] tcnt_r;
  reg  [3:0] bitcnt_r;
  reg  [7:0] sh_r;
  reg        txing_r;
  reg        ackph_r;
  reg        addr_r;
  reg        ignore_r;
  reg        supp_lat_r;
  reg        data_flag_r;
  reg        sda_pull_r;
  reg        scl_pull_r;
  reg  [3:0] free_cnt_r;
  // configuration
  reg        en_r;
  reg        supp_r;
  reg        busy_r;
  reg        ext_r;
  reg        toe_r;
  reg        fte_r;
  reg  [1:0] cs_r;
  // control and status
  reg        master_r;
  reg        tx_r;
  reg        sta_r;
  reg        sto_r;
  reg        ack_needed_r;
  reg        arbl_r;
  reg        ack_r;
  reg        si_r;
  // synchronisers
  reg        scl_m_r;
  reg        scl_s_r;
  reg        scl_d_r;
  reg        sda_m_r;
  reg        sda_s_r;
  reg        sda_d_r;
  // second buffer entry
  reg  [7:0] skid_d_r;
  reg        skid_v_r;

  wire       wr_cf     = sfr_wr & (sfr_addr == `SBC_CONFIG_ADDR);
  wire       wr_cn     = sfr_wr & (sfr_addr == `SBC_CTRL_STATUS_ADDR);
  wire       scl_rise  = scl_s_r & ~scl_d_r;
  wire       scl_fall  = ~scl_s_r & scl_d_r;
  wire       start_det = en_r & scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  wire       stop_det  = en_r & scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
  wire       own_cond  = (state_r == ST_START) | (state_r == ST_STOP2) | (state_r == ST_RST2);
  wire [4:0] hold_n    = ext_r ? `SBC_HOLD_EXT : `SBC_HOLD_STD;             // RQ25
  wire [4:0] setup_n   = ext_r ? `SBC_SETUP_EXT : `SBC_SETUP_STD;           // RQ25
  wire [4:0] low_n     = hold_n + setup_n;
  wire       tick_raw  = (cs_r == `SBC_CS_T0)  ? t0_ovf :                   // RQ7
                         (cs_r == `SBC_CS_T1)  ? t1_ovf :
                         (cs_r == `SBC_CS_T2H) ? t2h_ovf : t2l_ovf;
  wire       tick      = en_r & tick_raw;
  wire       free_hit  = fte_r & tick & scl_s_r & sda_s_r &
                         (free_cnt_r == `SBC_FREE_PERIODS);                 // RQ6
  wire       buf_push  = (state_r == ST_PUSH) & ~skid_v_r;
  wire       buf_pop   = rx_valid & rx_ready;
  wire       drv_bit   = txing_r & (bitcnt_r < 4'h8) ? sh_r[7] : 1'b1;
  wire       slave_ok  = ~ignore_r & ~supp_lat_r;

  task enter;
    input [3:0] s;
    begin
      state_r <= s;
      cnt_r   <= 5'h00;
      tcnt_r  <= 2'h0;
    end
  endtask

  // pin synchronisers: first stage feeds only the second
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  // two-entry receive buffer; a full buffer keeps the engine in ST_PUSH with scl low
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_data  <= 8'h00;
      rx_valid <= 1'b0;
      skid_d_r <= 8'h00;
      skid_v_r <= 1'b0;
    end
    else if (!rx_valid | buf_pop)
    begin
      if (skid_v_r)
      begin
        rx_data  <= skid_d_r;
        rx_valid <= 1'b1;
        skid_v_r <= buf_push;
        skid_d_r <= sh_r;
      end
      else
      begin
        rx_data  <= buf_push ? sh_r : rx_data;
        rx_valid <= buf_push;
      end
    end
    else if (buf_push)
    begin
      skid_d_r <= sh_r;
      skid_v_r <= 1'b1;
    end
  end

  // register read, timer 3 control and pin drivers
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sfr_rdata    <= 8'h00;
      t3_reload_hi <= 1'b0;
      t3_reload_lo <= 1'b0;
      scl_out      <= 1'b0;
      sda_out      <= 1'b0;
      scl_oe_n     <= 1'b1;
      sda_oe_n     <= 1'b1;
    end
    else
    begin
      if (sfr_addr == `SBC_CONFIG_ADDR)
        sfr_rdata <= {en_r, supp_r, busy_r, ext_r, toe_r, fte_r, cs_r};
      else if (sfr_addr == `SBC_CTRL_STATUS_ADDR)
        sfr_rdata <= {master_r, tx_r, sta_r, sto_r, ack_needed_r, arbl_r, ack_r, si_r};
      else
        sfr_rdata <= 8'h00;
      t3_reload_hi <= en_r & toe_r & scl_s_r;                                // RQ4
      t3_reload_lo <= en_r & toe_r & scl_s_r & ~timer3_split;                // RQ5
      scl_out      <= 1'b0;
      sda_out      <= 1'b0;
      // a set event flag holds scl in every state, idle after stop or timeout too
      scl_oe_n     <= ~(en_r & (scl_pull_r | si_r));                         // RQ26
      sda_oe_n     <= ~(en_r & sda_pull_r);
    end
  end

  // registers and byte engine
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ST_IDLE;  cnt_r <= 5'h00;  tcnt_r <= 2'h0;
      bitcnt_r <= 4'h0;  sh_r <= 8'h00;  txing_r <= 1'b0;  ackph_r <= 1'b0;
      addr_r <= 1'b0;  ignore_r <= 1'b0;  supp_lat_r <= 1'b0;  data_flag_r <= 1'b0;
      sda_pull_r <= 1'b0;  scl_pull_r <= 1'b0;  free_cnt_r <= 4'h0;
      {en_r, supp_r, ext_r, toe_r, fte_r, cs_r} <= 7'h00;
      busy_r <= 1'b0;
      {master_r, tx_r, sta_r, sto_r, ack_needed_r, arbl_r, ack_r, si_r} <= `SBC_CTRL_STATUS_RST;
    end
    else
    begin
      // software writes come first so that hardware sets in the same cycle win
      if (wr_cf)
      begin
        en_r  <= sfr_wdata[`SBC_CF_ENABLE];                                  // RQ1
        supp_r <= sfr_wdata[`SBC_CF_SUPP];
        ext_r <= sfr_wdata[`SBC_CF_EXTENDED_SETUP_HOLD];
        toe_r <= sfr_wdata[`SBC_CF_TOE];
        fte_r <= sfr_wdata[`SBC_CF_FTE];
        cs_r  <= sfr_wdata[`SBC_CF_CS_HI:`SBC_CF_CS_LO];
      end
      if (wr_cn)
      begin
        sta_r <= sfr_wdata[`SBC_CN_BEGIN];
        sto_r <= sfr_wdata[`SBC_CN_HALT];
        ack_r <= sfr_wdata[`SBC_CN_ACK];
        si_r  <= sfr_wdata[`SBC_CN_EVENT];
        if (!sfr_wdata[`SBC_CN_EVENT])
          arbl_r <= 1'b0;                                                    // RQ17
      end
      if (data_wr)
      begin
        sh_r        <= data_in;
        data_flag_r <= 1'b1;
        tx_r        <= 1'b1;                                                 // RQ21
      end
      if (cnt_r != 5'h1f)
        cnt_r <= cnt_r + 5'h01;
      if (tick & (tcnt_r != 2'h3))
        tcnt_r <= tcnt_r + 2'h1;
      // bus-free detection needs the selected clock source even as a slave
      if (!(scl_s_r & sda_s_r))
        free_cnt_r <= 4'h0;
      else if (tick & (free_cnt_r != `SBC_FREE_PERIODS))
        free_cnt_r <= free_cnt_r + 4'h1;
      if (start_det)
        busy_r <= 1'b1;                                                      // RQ3
      if (stop_det | (free_hit & busy_r))
        busy_r <= 1'b0;                                                      // RQ3
      if (free_hit & busy_r)
      begin
        si_r  <= 1'b1;                                                       // RQ23
        sto_r <= 1'b1;
        enter(ST_IDLE);
        sda_pull_r <= 1'b0;
        scl_pull_r <= 1'b0;
      end
      // conditions made by another party
      if (start_det & !own_cond)
      begin
        ignore_r   <= 1'b0;                                                  // RQ15
        supp_lat_r <= supp_r;                                                // RQ2
        tx_r       <= 1'b0;                                                  // RQ21
        addr_r     <= 1'b1;
        txing_r    <= 1'b0;
        bitcnt_r   <= 4'h0;
        sda_pull_r <= 1'b0;
        scl_pull_r <= 1'b0;
        enter(ST_HIGH);
        if (master_r & !sta_r)
        begin
          arbl_r   <= 1'b1;                                                  // RQ16
          si_r     <= 1'b1;                                                  // RQ19
          master_r <= 1'b0;                                                  // RQ20
        end
      end
      else if (stop_det & !own_cond)
      begin
        if (master_r)
        begin
          arbl_r   <= 1'b1;                                                  // RQ16
          sto_r    <= 1'b1;                                                  // RQ22
          si_r     <= 1'b1;
          master_r <= 1'b0;
        end
        else if (!addr_r & slave_ok & (state_r != ST_IDLE))
        begin
          sto_r <= 1'b1;                                                     // RQ22
          si_r  <= 1'b1;                                                     // RQ19
        end
        sda_pull_r <= 1'b0;
        scl_pull_r <= 1'b0;
        enter(ST_IDLE);
      end
      else
      begin
        case (state_r)
          ST_IDLE:
          begin
            sda_pull_r <= 1'b0;
            scl_pull_r <= 1'b0;
            if (en_r & sta_r & !busy_r & !master_r & !si_r)
              enter(ST_START);                                               // RQ8
          end
          ST_START:
          begin
            sda_pull_r <= 1'b1;
            // leave only once our own sda fall is seen, so the detector files it as ours
            if ((tcnt_r != 2'h0) & (cnt_r >= hold_n) & !sda_s_r)
            begin
              scl_pull_r  <= 1'b1;
              master_r    <= 1'b1;                                           // RQ20
              tx_r        <= 1'b1;                                           // RQ21
              si_r        <= 1'b1;                                           // RQ19
              busy_r      <= 1'b1;
              ackph_r     <= 1'b0;
              addr_r      <= 1'b0;
              data_flag_r <= 1'b0;
              enter(ST_WAIT);
            end
          end
          ST_WAIT:
          begin
            scl_pull_r <= 1'b1;                                              // RQ18
            if (ackph_r)
              sda_pull_r <= ack_r;                                           // RQ13
            if (!si_r)
            begin
              if (ackph_r)
              begin
                bitcnt_r <= 4'h8;
                enter(master_r ? ST_LOW : ST_HIGH);
                scl_pull_r <= master_r;
              end
              else if (master_r & sto_r)
                enter(ST_STOP1);                                             // RQ10
              else if (master_r & sta_r)
                enter(ST_RST1);                                              // RQ9
              else
              begin
                txing_r     <= data_flag_r;
                tx_r        <= data_flag_r;                                  // RQ21
                data_flag_r <= 1'b0;
                bitcnt_r    <= 4'h0;
                scl_pull_r  <= master_r;
                enter(master_r ? ST_LOW : ST_HIGH);
              end
            end
          end
          ST_LOW:
          begin
            if (cnt_r == hold_n)
              sda_pull_r <= (bitcnt_r == 4'h8) & !txing_r ? ack_r : ~drv_bit;
            if ((tcnt_r != 2'h0) & (cnt_r >= low_n))
            begin
              scl_pull_r <= 1'b0;                                            // RQ24
              enter(ST_HIGH);
            end
          end
          ST_HIGH:
          begin
            if (!master_r & (cnt_r == hold_n))
              sda_pull_r <= (bitcnt_r == 4'h8) ? (ackph_r & ack_r) :
                            (~drv_bit & slave_ok);
            if (!scl_s_r)
              tcnt_r <= 2'h0;
            if (scl_rise)
            begin
              if (bitcnt_r < 4'h8)
              begin
                sh_r <= {sh_r[6:0], sda_s_r};
                if (txing_r & drv_bit & !sda_s_r)
                begin
                  arbl_r     <= 1'b1;                                        // RQ16
                  si_r       <= 1'b1;                                        // RQ19
                  master_r   <= 1'b0;                                        // RQ20
                  tx_r       <= 1'b0;                                        // RQ21
                  ignore_r   <= 1'b1;
                  sda_pull_r <= 1'b0;
                  scl_pull_r <= 1'b0;
                  enter(ST_IDLE);
                end
              end
              else if (txing_r)
                ack_r <= ~sda_s_r;                                           // RQ14
            end
            else if (master_r ? (scl_s_r & (tcnt_r >= `SBC_HIGH_TICKS)) : scl_fall)
            begin
              scl_pull_r <= master_r;
              if (bitcnt_r == 4'h7)
              begin
                if (txing_r)
                begin
                  bitcnt_r <= 4'h8;
                  enter(master_r ? ST_LOW : ST_HIGH);
                end
                else
                  enter(ST_PUSH);
              end
              else if (bitcnt_r == 4'h8)
              begin
                ack_needed_r <= 1'b0;                                             // RQ12
                ackph_r <= 1'b0;
                if (!txing_r & !ack_r & addr_r)
                begin
                  ignore_r   <= 1'b1;                                        // RQ15
                  scl_pull_r <= 1'b0;
                  enter(ST_IDLE);
                end
                else if (!slave_ok & !master_r)
                begin
                  ignore_r   <= 1'b1;                                        // RQ2
                  sda_pull_r <= 1'b0;
                  enter(ST_IDLE);
                end
                else
                begin
                  si_r   <= si_r | txing_r;                                  // RQ19
                  addr_r <= 1'b0;
                  enter(ST_WAIT);
                end
              end
              else
              begin
                bitcnt_r <= bitcnt_r + 4'h1;
                sh_r     <= txing_r ? {sh_r[6:0], 1'b0} : sh_r;
                enter(master_r ? ST_LOW : ST_HIGH);
              end
            end
          end
          ST_PUSH:
          begin
            scl_pull_r <= 1'b1;
            if (!slave_ok & !master_r)
            begin
              bitcnt_r <= 4'h8;                                              // RQ2
              scl_pull_r <= 1'b0;
              enter(ST_HIGH);
            end
            else if (!skid_v_r)
            begin
              ack_needed_r <= 1'b1;                                               // RQ12
              si_r    <= 1'b1;                                               // RQ19
              ack_r   <= 1'b0;
              sta_r   <= sta_r | (addr_r & !master_r);                       // RQ22
              ackph_r <= 1'b1;
              enter(ST_WAIT);
            end
          end
          ST_STOP1:
          begin
            if (cnt_r == hold_n)
              sda_pull_r <= 1'b1;
            if ((tcnt_r != 2'h0) & (cnt_r >= low_n))
            begin
              scl_pull_r <= 1'b0;
              enter(ST_STOP2);
            end
          end
          ST_STOP2:
          begin
            if (!scl_s_r & (cnt_r > 5'h04))
            begin
              arbl_r   <= 1'b1;                                              // RQ16
              si_r     <= 1'b1;
              master_r <= 1'b0;
              enter(ST_IDLE);
            end
            else if (scl_s_r & (tcnt_r != 2'h0))
            begin
              sda_pull_r <= 1'b0;
              sto_r      <= 1'b0;                                            // RQ10
              master_r   <= 1'b0;                                            // RQ20
              busy_r     <= 1'b0;
              enter(sta_r ? ST_START : ST_IDLE);                             // RQ11
            end
          end
          ST_RST1:
          begin
            if (cnt_r == hold_n)
              sda_pull_r <= 1'b0;
            if ((tcnt_r != 2'h0) & (cnt_r >= low_n))
            begin
              scl_pull_r <= 1'b0;
              enter(ST_RST2);
            end
          end
          ST_RST2:
          begin
            if (!scl_s_r & (cnt_r > 5'h04))
            begin
              arbl_r   <= 1'b1;                                              // RQ16
              si_r     <= 1'b1;
              master_r <= 1'b0;
              enter(ST_IDLE);
            end
            else if (scl_s_r & (tcnt_r != 2'h0))
              enter(ST_START);                                               // RQ9
          end
          default:
            enter(ST_IDLE);
        endcase
      end
      // disable drops everything back to idle with the lines released
      if (!en_r)
      begin
        enter(ST_IDLE);                                                      // RQ26
        master_r   <= 1'b0;
        sda_pull_r <= 1'b0;
        scl_pull_r <= 1'b0;
        ignore_r   <= 1'b0;
        busy_r     <= 1'b0;
      end
    end
  end

endmodule // sbc_smbus_ctrl

// File: tb/sbc_asserts.sv
// assertion checker for the serial bus control block
`timescale 1ns/100ps
module sbc_asserts (
  // clock and reset
  input wire       ref_clk,
  input wire       resetn,
  // register port
  input wire [7:0] sfr_addr,
  input wire       sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  // timer 3 and pins
  input wire       timer3_split,
  input wire       t3_reload_hi,
  input wire       t3_reload_lo,
  input wire       scl_in,
  input wire       scl_out,
  input wire       scl_oe_n,
  input wire       sda_out,
  input wire       sda_oe_n
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  property p_lohi; t3_reload_lo |-> t3_reload_hi; endproperty
  a_lohi: assert property (p_lohi) else $error("low reload alone");
  property p_split; t3_reload_lo |-> !$past(timer3_split); endproperty
  a_split: assert property (p_split) else $error("low reload in split");
  property p_scl; !scl_in [*4] |=> !t3_reload_hi; endproperty
  a_scl: assert property (p_scl) else $error("reload with scl low");
  property p_od; !scl_out && !sda_out; endproperty
  a_od: assert property (p_od) else $error("pin value high");
  property p_arb; sfr_wr && sfr_addr == 8'hc0 && !sfr_wdata[0] ##1
    sfr_addr == 8'hc0 |=> !sfr_rdata[2]; endproperty
  a_arb: assert property (p_arb) else $error("lost flag kept");
  property p_cfg; sfr_wr && sfr_addr == 8'hc1 ##1 sfr_addr == 8'hc1 && !sfr_wr
    |=> (sfr_rdata & 8'hdf) == ($past(sfr_wdata, 2) & 8'hdf); endproperty
  a_cfg: assert property (p_cfg) else $error("config readback");
  property p_off; $past(sfr_addr) == 8'hc1 && !sfr_rdata[7] |-> ##2 scl_oe_n && sda_oe_n;
  endproperty
  a_off: assert property (p_off) else $error("lines held while off");
  property p_ev; $past(sfr_addr) == 8'hc0 && sfr_rdata[0] |-> !scl_oe_n; endproperty
  a_ev: assert property (p_ev) else $error("scl free during event");
endmodule // sbc_asserts
bind sbc_smbus_ctrl sbc_asserts sbc_asserts_inst (.ref_clk(ref_clk), .resetn(resetn),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .timer3_split(timer3_split), .t3_reload_hi(t3_reload_hi), .t3_reload_lo(t3_reload_lo),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n));

// File: tb/sbc_bus_model.sv
// far side of the bus: pull-ups and a device that can stretch scl
`timescale 1ns/100ps
module sbc_bus_model (
  // device pin enables
  input  wire scl_oe_n,
  input  wire sda_oe_n,
  // far side stretches scl or pulls sda
  input  wire hold_scl,
  input  wire hold_sda,
  // resolved lines
  output wire scl,
  output wire sda
);
  // open drain: any low wins, else pulled high
  assign scl = scl_oe_n & ~hold_scl;
  assign sda = sda_oe_n & ~hold_sda;
endmodule // sbc_bus_model

// File: tb/tb_top.sv
// self-checking testbench of the serial bus control block
`timescale 1ns/100ps
module tb_top;
  reg        ref_clk = 1'b0;
  reg        resetn = 1'b0;
  reg  [7:0] sfr_addr = 8'h00;
  reg        sfr_wr = 1'b0;
  reg  [7:0] sfr_wdata = 8'h00;
  reg  [3:0] ovf = 4'h0;
  reg        split = 1'b0;
  reg        hold_scl = 1'b0;
  reg        hold_sda = 1'b0;
  wire [7:0] rdata;
  wire       rl_hi;
  wire       rl_lo;
  wire       scl_oe_n;
  wire       sda_oe_n;
  wire       scl;
  wire       sda;
  integer    n_mismatch = 0;
  integer    num_checks = 0;
  integer    i;
  always #12.5 ref_clk = ~ref_clk;
  sbc_smbus_ctrl sbc_smbus_ctrl_inst (.ref_clk(ref_clk), .resetn(resetn),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(rdata),
    .data_wr(1'b0), .data_in(8'h00), .rx_data(), .rx_valid(), .rx_ready(1'b1),
    .t0_ovf(ovf[0]), .t1_ovf(ovf[1]), .t2h_ovf(ovf[2]), .t2l_ovf(ovf[3]),
    .timer3_split(split), .t3_reload_hi(rl_hi), .t3_reload_lo(rl_lo), .scl_in(scl),
    .scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(), .sda_oe_n(sda_oe_n));
  sbc_bus_model sbc_bus_model_inst (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
    .hold_scl(hold_scl), .hold_sda(hold_sda), .scl(scl), .sda(sda));
  task chk(input [7:0] got, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge ref_clk);
      sfr_wr <= 1'b0;
    end
  endtask
  // registered read: data lands one edge after the address
  task rd(input [7:0] a, input [7:0] m, input [7:0] e);
    begin
      @(posedge ref_clk);
      sfr_addr <= a;
      @(posedge ref_clk);
      #1 chk(rdata & m, e);
    end
  endtask
  task tick(input [3:0] m, input integer k);
    begin
      repeat (k)
      begin
        @(posedge ref_clk);
        ovf <= m;
        @(posedge ref_clk);
        ovf <= 4'h0;
        repeat (2) @(posedge ref_clk);
      end
    end
  endtask
  task t_reset;
    begin
      rd(8'hc0, 8'hff, 8'h00);
      rd(8'hc1, 8'hff, 8'h00);
      rd(8'hc5, 8'hff, 8'h00);
    end
  endtask
  task t_timer;
    begin
      wr(8'hc1, 8'h88);
      repeat (4) @(posedge ref_clk);
      chk({6'h00, rl_hi, rl_lo}, 8'h03);
      split <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk({6'h00, rl_hi, rl_lo}, 8'h02);
      hold_scl <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk({6'h00, rl_hi, rl_lo}, 8'h00);
      hold_scl <= 1'b0;
      split <= 1'b0;
      rd(8'hc1, 8'hff, 8'h88);
    end
  endtask
  // far-side start makes the bus busy; other timers must not count toward the free timeout
  task t_free;
    begin
      wr(8'hc1, 8'h00);
      wr(8'hc1, 8'h85);
      hold_sda <= 1'b1;
      repeat (6) @(posedge ref_clk);
      hold_scl <= 1'b1;
      repeat (6) @(posedge ref_clk);
      hold_sda <= 1'b0;
      repeat (6) @(posedge ref_clk);
      hold_scl <= 1'b0;
      rd(8'hc1, 8'h20, 8'h20);
      tick(4'h1, 20);
      rd(8'hc0, 8'h01, 8'h00);
      tick(4'h2, 10);
      rd(8'hc0, 8'h01, 8'h00);
      tick(4'h2, 1);
      rd(8'hc0, 8'h11, 8'h11);
      rd(8'hc1, 8'h20, 8'h00);
    end
  endtask
  task t_start;
    begin
      wr(8'hc0, 8'h00);
      wr(8'hc0, 8'h20);
      for (i = 0; i < 300 && scl_oe_n !== 1'b0; i = i + 1)
        tick(4'h2, 1);
      chk({7'h00, sda_oe_n}, 8'h00);
      repeat (8) @(posedge ref_clk);
      rd(8'hc0, 8'ha1, 8'ha1);
      tick(4'h2, 10);
      chk({7'h00, scl_oe_n}, 8'h00);
      rd(8'hc1, 8'h20, 8'h20);
      wr(8'hc0, 8'h00);
      wr(8'hc1, 8'h00);
      repeat (4) @(posedge ref_clk);
      chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
    end
  endtask
  task report_and_stop;
    begin
      if (n_mismatch == 0 && num_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial
  begin
    #2000000;
    n_mismatch = n_mismatch + 1;
    report_and_stop;
  end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset;
    t_timer;
    t_free;
    t_start;
    report_and_stop;
  end
endmodule // tb_top
